/* rtl/mfc_pkg.sv */
// constants, field layout and speed helper for the per-port flow-control and storm guard
// assumes a 250 MHz core clock and a link speed code from the port MAC
// Contract
// [R1] After a received pause, hold normal frames until the loaded timer expires.
// [R2] A pause arriving while paused reloads the timer with the new time.
// [R3] While paused, own flow control frames may still go out, nothing else.
// [R4] Decide to throttle from free buffer count and free queue space.
// [R5] Throttle by sending a pause carrying the largest pause time.
// [R6] When resources free up, send a pause carrying zero time.
// [R7] Separate assert and release levels keep throttling from chattering.
// [R8] Half duplex pressure uses same conditions, driving preamble for carrier deferral.
// [R9] During long pressure, drop carrier briefly then raise it again.
// [R10] Own queued frames interrupt pressure; pressure resumes afterwards while congested.
// [R11] Collision under pressure skips back-off and regenerates carrier at once.
// [R12] Generated pause frames carry the six-byte programmed switch address as source.
// [R13] Global pass-pause option; per-port flow control and pressure enables.
// [R14] Software enables no-excess-collision-drop and pressure on half duplex ports.
// [R15] Storm interval is 5 ms at 1000, 50 ms at 100, 500 ms at 10.
// [R16] Each interval clears the storm counter, then counts broadcast bytes.
// [R17] Storm rate global, enable per port, multicast counting optional.
// [R18] Storm rate resets to the one percent setting.
// [R19] With self filtering, drop frames whose source equals the switch address.
// [R20] Half duplex: drop a frame after 16 collisions unless drop is disabled.
// [R21] Once the storm limit is reached, drop counted frames until interval ends.
// [R22] Pause time counts in quanta of 512 bit times at current speed.
package mfc_pkg;
   // clock
   localparam int unsigned CLK_PERIOD_NS = 4;
   // pause quantum
   localparam int unsigned QUANTUM_BITS = 512;
   localparam int unsigned BIT_NS_10 = 100;
   localparam int unsigned BIT_NS_100 = 10;
   localparam int unsigned BIT_NS_1000 = 1;
   localparam int unsigned Q10_CYC = QUANTUM_BITS * BIT_NS_10 / CLK_PERIOD_NS;
   localparam int unsigned Q100_CYC = QUANTUM_BITS * BIT_NS_100 / CLK_PERIOD_NS;
   localparam int unsigned Q1000_CYC = QUANTUM_BITS * BIT_NS_1000 / CLK_PERIOD_NS;
   // storm intervals
   localparam int unsigned STORM_MS_10 = 500;
   localparam int unsigned STORM_MS_100 = 50;
   localparam int unsigned STORM_MS_1000 = 5;
   localparam int unsigned STORM10_CYC = STORM_MS_10 * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned STORM100_CYC = STORM_MS_100 * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned STORM1000_CYC = STORM_MS_1000 * 1000000 / CLK_PERIOD_NS;
   // line-rate bytes per interval are the same at every speed: 1% of them
   localparam logic [12:0] STORM_BYTES_PER_PCT = 13'h186a;
   // carrier pressure hold and gap
   localparam int unsigned BP_HOLD_NS = 80000;
   localparam int unsigned BP_GAP_NS = 640;
   localparam int unsigned BP_HOLD_CYC = BP_HOLD_NS / CLK_PERIOD_NS;
   localparam int unsigned BP_GAP_CYC = BP_GAP_NS / CLK_PERIOD_NS;
   // collisions
   localparam logic [4:0] EXC_COLL_LIMIT = 5'h10;
   // pause times
   localparam logic [15:0] PAUSE_MAX = 16'hffff;
   localparam logic [15:0] PAUSE_ZERO = 16'h0000;
   // speed codes
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // register offsets
   localparam logic [7:0] OFS_GLOBAL = 8'h00;
   localparam logic [7:0] OFS_PORT = 8'h04;
   localparam logic [7:0] OFS_THRESH = 8'h08;
   localparam logic [7:0] OFS_STORM = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MAC0 = 8'h20;
   localparam logic [7:0] OFS_MAC5 = 8'h34;
   // global fields
   localparam int unsigned GB_PASS_PAUSE = 0;
   localparam int unsigned GB_STORM_MCAST = 1;
   localparam int unsigned GB_NO_EXC_DROP = 2;
   // port fields
   localparam int unsigned PB_FC_EN = 0;
   localparam int unsigned PB_BP_EN = 1;
   localparam int unsigned PB_STORM_EN = 2;
   localparam int unsigned PB_SELF_EN = 3;
   // threshold fields
   localparam int unsigned TH_ASSERT_LSB = 0;
   localparam int unsigned TH_RELEASE_LSB = 16;
   // resets
   localparam logic [2:0] GLOBAL_RST = 3'h0;
   localparam logic [3:0] PORT_RST = 4'h0;
   localparam logic [9:0] TH_ASSERT_RST = 10'h040;
   localparam logic [9:0] TH_RELEASE_RST = 10'h080;
   localparam logic [6:0] STORM_RATE_RST = 7'h01;
   localparam logic [7:0] MAC_BYTE_RST = 8'h00;

   function automatic logic [31:0] mfc_pick(input logic [1:0] spd, input logic [31:0] v10,
                                            input logic [31:0] v100, input logic [31:0] v1000);
      if (spd == SPD_1000) begin
         return v1000;
      end else if (spd == SPD_100) begin
         return v100;
      end
      return v10;
   endfunction
endpackage

/* rtl/mfc_pause_timer.sv */
// pause timer: counts received pause quanta down
// assumes cycles per quantum are given for the current speed
`timescale 1ns/1ns
`default_nettype none
module mfc_pause_timer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // load
   input wire logic load,
   input wire logic [15:0] quanta,
   input wire logic [15:0] quantum_cyc,
   // state
   output logic paused,
   output logic [15:0] remaining
);
   import mfc_pkg::*;

   logic [15:0] remain_reg;
   logic [15:0] sub_reg;

   ////////////////////////////////////////////////////////////////////////
   // [R2] reload on newer pause
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         remain_reg <= 16'h0000;
      end else if (load) begin
         remain_reg <= quanta;
      end else if (remain_reg != 16'h0000 && sub_reg + 16'h0001 >= quantum_cyc) begin
         remain_reg <= remain_reg - 16'h0001;
      end
   end

   // [R22] quantum of 512 bit times
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_reg <= 16'h0000;
      end else if (load || remain_reg == 16'h0000 || sub_reg + 16'h0001 >= quantum_cyc) begin
         sub_reg <= 16'h0000;
      end else begin
         sub_reg <= sub_reg + 16'h0001;
      end
   end

   assign paused = (remain_reg != 16'h0000);
   assign remaining = remain_reg;

   ////////////////////////////////////////////////////////////////////////
   reload_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      load |=> remain_reg == $past(quanta)) else $error("pause reload lost"); // [R2]
   quantum_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (paused && !load && $stable(remain_reg)) |-> sub_reg < quantum_cyc)
      else $error("quantum overrun"); // [R22]
endmodule
`default_nettype wire

/* rtl/mfc_guard.sv */
// per-port pause, carrier pressure, storm and self-address guard
// assumes rx/tx event strobes come from the port MAC on sys_clk; col_pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
module mfc_guard #(
   parameter int unsigned Q10_CYCLES = mfc_pkg::Q10_CYC,
   parameter int unsigned STORM10_CYCLES = mfc_pkg::STORM10_CYC,
   parameter int unsigned STORM100_CYCLES = mfc_pkg::STORM100_CYC,
   parameter int unsigned STORM1000_CYCLES = mfc_pkg::STORM1000_CYC,
   parameter int unsigned BP_HOLD_CYCLES = mfc_pkg::BP_HOLD_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // link state
   input wire logic [1:0] link_speed,
   input wire logic link_full_duplex,
   // receive header
   input wire logic rx_hdr_valid,
   input wire logic [13:0] rx_len,
   input wire logic rx_is_bcast,
   input wire logic rx_is_mcast,
   input wire logic rx_is_pause,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic [47:0] rx_sa,
   output logic rx_drop,
   output logic rx_pause_taken,
   // resources
   input wire logic [9:0] free_buffers,
   input wire logic [9:0] free_queue,
   // transmit
   input wire logic tx_pending,
   input wire logic tx_active,
   input wire logic tx_collision,
   input wire logic tx_done,
   input wire logic col_pin,
   output logic tx_normal_allow,
   output logic tx_ctrl_req,
   input wire logic tx_ctrl_ack,
   output logic [15:0] tx_ctrl_quanta,
   output logic [47:0] tx_ctrl_sa,
   output logic carrier_deferral_pressure,
   output logic tx_skip_backoff,
   output logic tx_excess_drop
);
   import mfc_pkg::*;

   typedef enum logic [1:0] {FC_IDLE, FC_SEND_ON, FC_ON, FC_SEND_OFF} mfc_fc_e;
   typedef enum logic {BP_HOLD, BP_GAP} mfc_bp_e;

   logic [2:0] global_reg;
   logic [3:0] port_reg;
   logic [9:0] th_assert_reg;
   logic [9:0] th_release_reg;
   logic [6:0] storm_rate_reg;
   logic [7:0] mac_reg [6];
   logic [31:0] rdata_reg;
   logic [47:0] switch_mac;
   logic congested_reg;
   mfc_fc_e fc_reg;
   logic [15:0] quanta_reg;
   mfc_bp_e bp_reg;
   logic [31:0] bp_cnt_reg;
   logic col_s1_reg;
   logic col_s2_reg;
   logic [4:0] coll_cnt_reg;
   logic excess_reg;
   logic [31:0] int_cnt_reg;
   logic [19:0] storm_cnt_reg;
   logic storm_hit_reg;
   logic drop_reg;
   logic pause_taken_reg;
   logic rx_paused;
   logic [15:0] pause_left;
   logic pause_load;
   logic [31:0] int_len;
   logic int_wrap;
   logic [19:0] storm_limit;
   logic storm_counted;
   logic self_hit;
   logic pause_eat;
   logic fc_en;
   logic bp_mode;
   logic bp_want;
   logic collide;

   assign switch_mac = {mac_reg[0], mac_reg[1], mac_reg[2], mac_reg[3], mac_reg[4], mac_reg[5]};
   assign fc_en = port_reg[PB_FC_EN];

   ////////////////////////////////////////////////////////////////////////
   // register writes
   // [R13] global and per-port enables
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_reg <= GLOBAL_RST;
         port_reg <= PORT_RST;
      end else if (reg_wr && reg_addr == OFS_GLOBAL) begin
         global_reg <= reg_wdata[2:0];
      end else if (reg_wr && reg_addr == OFS_PORT) begin
         port_reg <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         th_assert_reg <= TH_ASSERT_RST;
         th_release_reg <= TH_RELEASE_RST;
      end else if (reg_wr && reg_addr == OFS_THRESH) begin
         th_assert_reg <= reg_wdata[TH_ASSERT_LSB +: 10];
         th_release_reg <= reg_wdata[TH_RELEASE_LSB +: 10];
      end
   end

   // [R18] storm rate resets to 1%
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         storm_rate_reg <= STORM_RATE_RST;
      end else if (reg_wr && reg_addr == OFS_STORM) begin
         storm_rate_reg <= reg_wdata[6:0];
      end
   end

   // [R12] six byte-wide address settings
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 6; i++) begin
            mac_reg[i] <= MAC_BYTE_RST;
         end
      end else if (reg_wr && reg_addr >= OFS_MAC0 && reg_addr <= OFS_MAC5 &&
                   reg_addr[1:0] == 2'h0) begin
         mac_reg[3'(reg_addr[4:2])] <= reg_wdata[7:0];
      end
   end

   // reads answer one cycle later, unmapped reads zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_GLOBAL: rdata_reg <= {29'h0, global_reg};
            OFS_PORT: rdata_reg <= {28'h0, port_reg};
            OFS_THRESH: rdata_reg <= {6'h0, th_release_reg, 6'h0, th_assert_reg};
            OFS_STORM: rdata_reg <= {25'h0, storm_rate_reg};
            OFS_STATUS: rdata_reg <= {pause_left, 12'h0, storm_hit_reg,
                                      carrier_deferral_pressure, congested_reg, rx_paused};
            8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34:
               rdata_reg <= {24'h0, mac_reg[3'(reg_addr[4:2])]};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // receive pause
   assign pause_eat = rx_hdr_valid && rx_is_pause && fc_en && link_full_duplex;
   assign pause_load = pause_eat;

   mfc_pause_timer u_pause (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(pause_load),
      .quanta(rx_pause_quanta),
      .quantum_cyc(16'(mfc_pick(link_speed, Q10_CYCLES, Q100_CYC, Q1000_CYC))),
      .paused(rx_paused),
      .remaining(pause_left)
   );

   // [R1] hold normal frames while paused
   // [R3] control frames bypass this gate
   assign tx_normal_allow = !rx_paused;

   ////////////////////////////////////////////////////////////////////////
   // congestion with hysteresis
   // [R4] [R7] assert below one level, release at or above another
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         congested_reg <= 1'b0;
      end else if (free_buffers < th_assert_reg || free_queue < th_assert_reg) begin
         congested_reg <= 1'b1;
      end else if (free_buffers >= th_release_reg && free_queue >= th_release_reg) begin
         congested_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pause transmit
   // [R5] [R6] max time on congestion, zero time on release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fc_reg <= FC_IDLE;
         quanta_reg <= PAUSE_ZERO;
      end else begin
         unique case (fc_reg)
            FC_IDLE: begin
               if (congested_reg && fc_en && link_full_duplex) begin
                  fc_reg <= FC_SEND_ON;
                  quanta_reg <= PAUSE_MAX;
               end
            end
            FC_SEND_ON: begin
               if (tx_ctrl_ack) begin
                  fc_reg <= FC_ON;
               end
            end
            FC_ON: begin
               if (!congested_reg || !fc_en || !link_full_duplex) begin
                  fc_reg <= FC_SEND_OFF;
                  quanta_reg <= PAUSE_ZERO;
               end
            end
            FC_SEND_OFF: begin
               if (tx_ctrl_ack) begin
                  fc_reg <= FC_IDLE;
               end
            end
         endcase
      end
   end

   assign tx_ctrl_req = (fc_reg == FC_SEND_ON) || (fc_reg == FC_SEND_OFF);
   assign tx_ctrl_quanta = quanta_reg;
   // [R12] source address of generated pause
   assign tx_ctrl_sa = switch_mac;

   ////////////////////////////////////////////////////////////////////////
   // half-duplex carrier pressure
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         col_s1_reg <= 1'b0;
         col_s2_reg <= 1'b0;
      end else begin
         col_s1_reg <= col_pin;
         col_s2_reg <= col_s1_reg;
      end
   end

   // [R8] same condition as full duplex
   assign bp_mode = port_reg[PB_BP_EN] && !link_full_duplex && congested_reg;
   // [R10] own frames interrupt pressure
   assign bp_want = bp_mode && !tx_pending && !tx_active;
   assign collide = col_s2_reg || tx_collision;

   // [R9] periodic short carrier drop
   // [R11] collision restarts carrier at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bp_reg <= BP_HOLD;
         bp_cnt_reg <= 32'h0000_0000;
      end else if (!bp_want || (collide && bp_mode)) begin
         bp_reg <= BP_HOLD;
         bp_cnt_reg <= 32'h0000_0000;
      end else begin
         unique case (bp_reg)
            BP_HOLD: begin
               if (bp_cnt_reg + 32'h1 >= BP_HOLD_CYCLES) begin
                  bp_reg <= BP_GAP;
                  bp_cnt_reg <= 32'h0000_0000;
               end else begin
                  bp_cnt_reg <= bp_cnt_reg + 32'h1;
               end
            end
            BP_GAP: begin
               if (bp_cnt_reg + 32'h1 >= BP_GAP_CYC) begin
                  bp_reg <= BP_HOLD;
                  bp_cnt_reg <= 32'h0000_0000;
               end else begin
                  bp_cnt_reg <= bp_cnt_reg + 32'h1;
               end
            end
         endcase
      end
   end

   assign carrier_deferral_pressure = (bp_want && bp_reg == BP_HOLD) || (bp_mode && collide);
   // [R11] no back-off while pressure is active
   assign tx_skip_backoff = bp_mode;

   ////////////////////////////////////////////////////////////////////////
   // excessive collisions
   // [R20] drop after 16 in a row
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         coll_cnt_reg <= 5'h00;
         excess_reg <= 1'b0;
      end else begin
         excess_reg <= 1'b0;
         if (tx_done || link_full_duplex) begin
            coll_cnt_reg <= 5'h00;
         end else if (tx_collision) begin
            if (coll_cnt_reg + 5'h01 >= EXC_COLL_LIMIT) begin
               coll_cnt_reg <= 5'h00;
               excess_reg <= !global_reg[GB_NO_EXC_DROP];
            end else begin
               coll_cnt_reg <= coll_cnt_reg + 5'h01;
            end
         end
      end
   end
   assign tx_excess_drop = excess_reg;

   ////////////////////////////////////////////////////////////////////////
   // storm guard
   // [R15] speed-dependent interval
   assign int_len = mfc_pick(link_speed, STORM10_CYCLES, STORM100_CYCLES, STORM1000_CYCLES);
   assign int_wrap = (int_cnt_reg + 32'h1 >= int_len);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_cnt_reg <= 32'h0000_0000;
      end else if (int_wrap) begin
         int_cnt_reg <= 32'h0000_0000;
      end else begin
         int_cnt_reg <= int_cnt_reg + 32'h1;
      end
   end

   // [R17] global rate, per-port enable, optional multicast
   assign storm_limit = 20'(storm_rate_reg) * 20'(STORM_BYTES_PER_PCT);
   assign storm_counted = port_reg[PB_STORM_EN] &&
                          (rx_is_bcast || (rx_is_mcast && global_reg[GB_STORM_MCAST]));

   // [R16] clear at interval start, then count bytes
   // [R21] limit reached: drop till interval end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         storm_cnt_reg <= 20'h00000;
         storm_hit_reg <= 1'b0;
      end else if (int_wrap) begin
         storm_cnt_reg <= 20'h00000;
         storm_hit_reg <= 1'b0;
      end else if (rx_hdr_valid && storm_counted && !storm_hit_reg) begin
         if (storm_cnt_reg >= storm_limit) begin
            storm_hit_reg <= 1'b1;
         end else begin
            storm_cnt_reg <= storm_cnt_reg + 20'(rx_len);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive verdict
   // [R19] self-address filter
   assign self_hit = port_reg[PB_SELF_EN] && (rx_sa == switch_mac);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drop_reg <= 1'b0;
         pause_taken_reg <= 1'b0;
      end else begin
         // [R13] consumed unless pass-through is set
         pause_taken_reg <= pause_eat && !global_reg[GB_PASS_PAUSE];
         drop_reg <= rx_hdr_valid && (self_hit || (storm_counted &&
                     (storm_hit_reg || storm_cnt_reg >= storm_limit)));
      end
   end
   assign rx_drop = drop_reg;
   assign rx_pause_taken = pause_taken_reg;

   ////////////////////////////////////////////////////////////////////////
   sequence cong_seq;
      fc_reg == FC_IDLE && congested_reg && fc_en && link_full_duplex;
   endsequence
   sequence max_req_seq;
      tx_ctrl_req && tx_ctrl_quanta == PAUSE_MAX;
   endsequence

   pause_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rx_paused |-> !tx_normal_allow) else $error("normal frame while paused"); // [R1]
   pause_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cong_seq |=> max_req_seq) else $error("no max pause on congestion"); // [R5]
   pause_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fc_reg == FC_ON && !congested_reg) |=> tx_ctrl_req && tx_ctrl_quanta == PAUSE_ZERO)
      else $error("no zero pause on release"); // [R6]
   hyst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (congested_reg && free_buffers < th_release_reg) |=> congested_reg)
      else $error("released below release level"); // [R7]
   own_frame_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tx_pending && !collide) |-> !carrier_deferral_pressure)
      else $error("pressure over own frame"); // [R10]
   col_press_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (bp_mode && collide) |-> carrier_deferral_pressure && tx_skip_backoff)
      else $error("no carrier on collision"); // [R11]
   gap_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (bp_want && bp_reg == BP_GAP && !collide) |-> !carrier_deferral_pressure)
      else $error("carrier during gap"); // [R9]
   storm_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      int_wrap |=> storm_cnt_reg == 20'h00000 && !storm_hit_reg)
      else $error("storm count not cleared"); // [R16]
   self_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rx_hdr_valid && self_hit) |=> rx_drop) else $error("own source not dropped"); // [R19]
   sa_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tx_ctrl_req |-> tx_ctrl_sa[7:0] == mac_reg[5]) else $error("pause source wrong"); // [R12]
endmodule
`default_nettype wire

/* dv/mfc_partner.sv */
// link partner model: emits receive headers, takes pause frames
// assumes bench raises send for one sys_clk cycle per frame
`timescale 1ns/1ns
`default_nettype none
module mfc_partner (
   // clock
   input wire logic sys_clk,
   // bench side
   input wire logic send,
   input wire logic [15:0] quanta,
   input wire logic [47:0] sa,
   // header
   output logic rx_hdr_valid,
   output logic [15:0] rx_pause_quanta,
   output logic [47:0] rx_sa,
   // pause frames
   input wire logic tx_ctrl_req,
   output logic tx_ctrl_ack
);
   // fields are garbage outside the header pulse
   assign rx_hdr_valid = send;
   assign rx_pause_quanta = send ? quanta : ~quanta;
   assign rx_sa = send ? sa : ~sa;
   // one-cycle ack per request; the high ack masks the falling request
   always @(posedge sys_clk) begin
      tx_ctrl_ack <= tx_ctrl_req && !tx_ctrl_ack;
   end
endmodule
`default_nettype wire

/* dv/mfc_guard_tb.sv */
// self-checking bench for the port guard
// assumes 1000 Mb/s link, full duplex until the half duplex pressure and collision checks
`timescale 1ns/1ns
`default_nettype none
module mfc_guard_tb;
   import mfc_pkg::*;
   logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 0, pz = 0;
   logic hv, d, t, allow, creq, cack;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
   logic [15:0] q = 16'h0, rxq, cq;
   logic [47:0] sa = 48'h0, mac, s, rxs, csa;
   logic [9:0] fb = 10'h3ff;
   logic fd = 1'b1, pend = 1'b0, coll = 1'b0, bc = 1'b0, cdp, sk, xd;
   logic [13:0] len = 14'h40;
   int n_mismatch = 0, num_checks = 0, l, sum = 0;
   // short hold and storm interval keep the run brief
   localparam int HOLD = 50, SL = 400;
   always #2 sys_clk = ~sys_clk;
   mfc_partner mfc_partner_inst (.sys_clk(sys_clk), .send(send), .quanta(q), .sa(sa),
      .rx_hdr_valid(hv), .rx_pause_quanta(rxq), .rx_sa(rxs), .tx_ctrl_req(creq),
      .tx_ctrl_ack(cack));
   mfc_guard #(.BP_HOLD_CYCLES(HOLD), .STORM1000_CYCLES(SL)) mfc_guard_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_speed(SPD_1000), .link_full_duplex(fd), .rx_hdr_valid(hv), .rx_len(len),
      .rx_is_bcast(bc), .rx_is_mcast(1'b0), .rx_is_pause(pz), .rx_pause_quanta(rxq),
      .rx_sa(rxs), .rx_drop(d), .rx_pause_taken(t), .free_buffers(fb), .free_queue(fb),
      .tx_pending(pend), .tx_active(1'b0), .tx_collision(coll), .tx_done(1'b0),
      .col_pin(1'b0), .tx_normal_allow(allow), .tx_ctrl_req(creq), .tx_ctrl_ack(cack),
      .tx_ctrl_quanta(cq), .tx_ctrl_sa(csa), .carrier_deferral_pressure(cdp),
      .tx_skip_backoff(sk), .tx_excess_drop(xd));
   //////////
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic rx(input logic p, input logic [15:0] qq, input logic [47:0] ss);
      @(posedge sys_clk);
      send <= 1'b1;
      pz <= p;
      q <= qq;
      sa <= ss;
      @(posedge sys_clk);
      send <= 1'b0;
      pz <= 1'b0;
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_req;
      repeat (20) if (creq !== 1'b1) cyc(1);
      chk(creq, 1'b1);
   endtask
   // one-cycle collision pulses, a quiet cycle before each
   task automatic hit(input int n);
      repeat (n) begin
         cyc(1);
         coll <= 1'b1;
         cyc(1);
         coll <= 1'b0;
      end
   endtask
   // limit after reset: one percent of the interval's line-rate bytes
   function automatic logic sdrop(input int acc);
      return acc >= int'(STORM_RATE_RST) * int'(STORM_BYTES_PER_PCT);
   endfunction
   //////////
   initial begin
      #40000 n_mismatch++;
      end_sim;
   end
   initial begin
      void'($urandom(32'hfc65));
      mac = 48'({$urandom, $urandom});
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(OFS_STORM);
      chk(v, 32'h1);
      rd(8'h40);
      chk(v, 32'h0);
      for (int i = 0; i < 6; i++) wr(OFS_MAC0 + 8'(4 * i), {24'h0, mac[47 - 8 * i -: 8]});
      wr(OFS_PORT, 32'hd);
      for (int i = 0; i < 8; i++) begin
         s = (i % 2) ? mac : 48'({$urandom, $urandom});
         rx(1'b0, 16'h0, s);
         chk(d, s == mac);
      end
      // broadcast burst well inside the first storm interval
      bc <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         l = 2000 + $urandom % 3000;
         len <= 14'(l);
         rx(1'b0, 16'h0, ~mac);
         chk(d, sdrop(sum));
         if (!sdrop(sum)) sum += l;
      end
      cyc(SL);
      rx(1'b0, 16'h0, ~mac);
      chk(d, 1'b0);
      bc <= 1'b0;
      rx(1'b1, 16'h2, mac ^ 48'h1);
      chk({t, allow}, 2'b10);
      cyc(2 * Q1000_CYC - 8);
      chk(allow, 1'b0);
      rx(1'b1, 16'h1, mac ^ 48'h1);
      fb <= 10'h10;
      wait_req;
      chk(cq, PAUSE_MAX);
      chk(csa, mac);
      chk(allow, 1'b0);
      cyc(Q1000_CYC - 30);
      chk(allow, 1'b0);
      cyc(40);
      chk(allow, 1'b1);
      fb <= 10'h60;
      cyc(30);
      chk(creq, 1'b0);
      fb <= 10'h80;
      wait_req;
      chk(cq, PAUSE_ZERO);
      fd <= 1'b0;
      wr(OFS_GLOBAL, 32'h4);
      wr(OFS_PORT, 32'h2);
      fb <= 10'h10;
      cyc(2);
      chk({cdp, sk}, 2'b11);
      cyc(HOLD);
      chk(cdp, 1'b0);
      cyc(BP_GAP_CYC);
      chk(cdp, 1'b1);
      pend <= 1'b1;
      cyc(1);
      chk(cdp, 1'b0);
      pend <= 1'b0;
      cyc(1);
      chk(cdp, 1'b1);
      cyc(HOLD + 2);
      chk(cdp, 1'b0);
      coll <= 1'b1;
      #1 chk({cdp, sk}, 2'b11);
      cyc(1);
      coll <= 1'b0;
      chk(cdp, 1'b1);
      hit(15);
      chk(xd, 1'b0);
      wr(OFS_GLOBAL, 32'h0);
      hit(16);
      chk(xd, 1'b1);
      repeat (4) @(posedge sys_clk);
      end_sim;
   end
endmodule
`default_nettype wire
